//--- verilog/tttal_pkg.sv
// Constants for the thermal throttle timer and alert block
// Contract
// - Eight-bit limit register sets timer threshold, zero up to 5.825 seconds.
// - Timer above limit sets timer-limit flag in status bit 5 and alert.
// - Mask bit 5 set blocks alert but flag still sets.
// - Limit zero raises alert on the first throttle assertion.
// - Limit one raises alert once cumulative time passes 45.52 ms.
// - Config three bit 1 enables timer monitoring, cleared at reset.
// - Config four bits 1:0 select shared pin; throttle also needs enable. Output drive here needs neither.
// - Full-speed bit set drives running fans at 100% while asserted.
// - Full-speed bit clear leaves fans at present settings.
// - Fans not running are never raised to full speed.
// - Output mode pulls line low when temperature exceeds critical limit.
// - Line stays low while above limit; released at or below.
// - Once asserted, line stays low at least one monitoring cycle.
// - Separate critical limits for remote1, local, remote2 at consecutive addresses.
// - Bit 3 of each channel config enables output assertion for it.
// - Limit at or below -64 offset or -128 twos complement disables channel.
// - Timer accumulates, clears on read, saturates at full scale.
// - Bit 0 sets on first assertion; then 22.76 ms per count.
// - Read during assertion clears, sets bit 0, counts on, checks zero limit.
// - Select 00 tach, 01 throttle, 10 alert, 11 general-purpose I/O.
package tttal_pkg;
    localparam logic [7:0] ADDR_R1_CFG = 8'h5f;
    localparam logic [7:0] ADDR_LOC_CFG = 8'h60;
    localparam logic [7:0] ADDR_R2_CFG = 8'h61;
    localparam logic [7:0] ADDR_R1_CRIT = 8'h6a;
    localparam logic [7:0] ADDR_LOC_CRIT = 8'h6b;
    localparam logic [7:0] ADDR_R2_CRIT = 8'h6c;
    localparam logic [7:0] ADDR_STATUS2 = 8'h42;
    localparam logic [7:0] ADDR_MASK2 = 8'h75;
    localparam logic [7:0] ADDR_CONFIG3 = 8'h78;
    localparam logic [7:0] ADDR_TIMER = 8'h79;
    localparam logic [7:0] ADDR_TLIMIT = 8'h7a;
    localparam logic [7:0] ADDR_CONFIG4 = 8'h7d;
    localparam int BIT_TLIMIT_FLAG = 5;
    localparam int BIT_MASK_TLIMIT = 5;
    localparam int BIT_TIMER_EN = 1;
    localparam int BIT_FULL_SPEED = 2;
    localparam int BIT_CH_OUT_EN = 3;
    localparam logic [7:0] RESET_CFG = 8'h00;
    localparam logic [7:0] RESET_LIMIT = 8'h7f;
    localparam logic [7:0] RESET_TLIMIT = 8'h00;
    localparam logic [7:0] OFFSET_MIN_LIMIT = 8'h00;
    localparam logic [7:0] TWOS_MIN_LIMIT = 8'h80;
    localparam logic [1:0] PIN_TACH = 2'h0;
    localparam logic [1:0] PIN_THROTTLE = 2'h1;
    localparam logic [1:0] PIN_ALERT = 2'h2;
    localparam logic [1:0] PIN_GPIO = 2'h3;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_US = 22760;
    localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_US / 1000;
endpackage

//--- verilog/tttal_top.sv
// Thermal throttle timer, limit flag, fan full_speed_on_throttle and throttle output drive
`timescale 1ns/10ps
module tttal_top
    import tttal_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int NFAN = 3
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic throttle_in,
    output logic throttle_out,
    output logic throttle_oe,
    input wire logic twos_mode,
    input wire logic meas_valid,
    input wire logic [1:0] meas_chan,
    input wire logic [7:0] meas_temp,
    input wire logic meas_quarter,
    input wire logic cycle_done,
    input wire logic [NFAN*8-1:0] fan_duty,
    output logic [NFAN*8-1:0] fan_duty_out,
    output logic smb_alert_n,
    output logic thermal_throttle_line_pin_select
);
    logic [7:0] ch_cfg [3];
    logic [7:0] crit [3];
    logic [7:0] next_ch_cfg [3];
    logic [7:0] next_crit [3];
    logic [7:0] mask2, config3, tlimit, config4;
    logic [7:0] next_mask2, next_config3, next_tlimit, next_config4;
    logic [7:0] timer, next_timer;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic flag, next_flag;
    logic [2:0] over, next_over;
    logic [2:0] held, next_held;
    logic [7:0] next_rdata;
    logic next_thr_out, next_oe, next_alert_n;
    logic [NFAN*8-1:0] next_fan;
    logic mon_on, asserted, timer_rd, hit;
    logic [8:0] timer_cmp;
    logic [31:0] step_end;
    // Value 1 spans two ticks, so bit 1 first sets once two ticks have passed
    localparam int FIRST_TICKS = 2 * TICK_CYC;

    // Throttle monitoring live only with enable and pin select both right; output drive needs neither
    always_comb begin
        mon_on = config3[BIT_TIMER_EN] && (config4[1:0] == PIN_THROTTLE);
        asserted = mon_on && !throttle_in;
        timer_rd = reg_rd && (reg_addr == ADDR_TIMER);
    end

    // Register writes; status clear on read of status is in the limit compare block
    always_comb begin
        next_ch_cfg = ch_cfg;
        next_crit = crit;
        next_mask2 = mask2;
        next_config3 = config3;
        next_tlimit = tlimit;
        next_config4 = config4;
        if (reg_wr) begin
            if (reg_addr == ADDR_R1_CFG) begin
                next_ch_cfg[0] = reg_wdata;
            end else if (reg_addr == ADDR_LOC_CFG) begin
                next_ch_cfg[1] = reg_wdata;
            end else if (reg_addr == ADDR_R2_CFG) begin
                next_ch_cfg[2] = reg_wdata;
            end else if (reg_addr == ADDR_R1_CRIT) begin
                next_crit[0] = reg_wdata;
            end else if (reg_addr == ADDR_LOC_CRIT) begin
                next_crit[1] = reg_wdata;
            end else if (reg_addr == ADDR_R2_CRIT) begin
                next_crit[2] = reg_wdata;
            end else if (reg_addr == ADDR_MASK2) begin
                next_mask2 = reg_wdata;
            end else if (reg_addr == ADDR_CONFIG3) begin
                next_config3 = reg_wdata;
            end else if (reg_addr == ADDR_TLIMIT) begin
                next_tlimit = reg_wdata;
            end else if (reg_addr == ADDR_CONFIG4) begin
                next_config4 = reg_wdata;
            end
        end
    end

    // Cumulative timer; first count spans two ticks, later ones one tick each
    always_comb begin
        step_end = (timer == 8'h01) ? 32'(FIRST_TICKS - 1) : 32'(TICK_CYC - 1);
        next_timer = timer;
        next_tick_cnt = tick_cnt;
        if (timer_rd) begin
            next_timer = asserted ? 8'h01 : 8'h00;
            next_tick_cnt = 32'h0;
        end else if (asserted) begin
            if (timer == 8'h00) begin
                next_timer = 8'h01;
            end else if (timer != 8'hff) begin
                if (tick_cnt >= step_end) begin
                    next_tick_cnt = 32'h0;
                    next_timer = timer + 8'h01;
                end else begin
                    next_tick_cnt = tick_cnt + 32'h1;
                end
            end
        end
    end

    // Limit compare: zero limit trips on first assertion, else time above limit
    always_comb begin
        timer_cmp = {1'b0, next_timer};
        hit = asserted && (tlimit == 8'h00 ? next_timer != 8'h00
            : timer_cmp > {1'b0, tlimit});
        next_flag = flag;
        // Set beats the read clear so a coincident event is kept
        if (reg_rd && reg_addr == ADDR_STATUS2) begin
            next_flag = 1'b0;
        end
        if (hit) begin
            next_flag = 1'b1;
        end
        next_alert_n = !(next_flag && !next_mask2[BIT_MASK_TLIMIT]);
    end

    // Output drive per channel; hold until the next cycle_done
    always_comb begin
        next_over = over;
        next_held = held;
        for (int i = 0; i < 3; i++) begin
            if (cycle_done) begin
                next_held[i] = 1'b0;
            end
            if (meas_valid && meas_chan == 2'(i)) begin
                if (!ch_cfg[i][BIT_CH_OUT_EN] ||
                    (twos_mode ? crit[i] == TWOS_MIN_LIMIT
                               : crit[i] == OFFSET_MIN_LIMIT)) begin
                    next_over[i] = 1'b0;
                end else if (twos_mode ? ($signed(meas_temp) > $signed(crit[i]) ||
                        (meas_temp == crit[i] && meas_quarter))
                        : (meas_temp > crit[i] || (meas_temp == crit[i] && meas_quarter)))
                        begin
                    if (!over[i]) begin
                        next_held[i] = 1'b1;
                    end
                    next_over[i] = 1'b1;
                end else if (!held[i]) begin
                    next_over[i] = 1'b0;
                end
            end
        end
        next_thr_out = 1'b0;
        next_oe = !(|next_over);
    end

    // Fan full_speed_on_throttle only for fans already running
    always_comb begin
        for (int f = 0; f < NFAN; f++) begin
            next_fan[f*8 +: 8] = fan_duty[f*8 +: 8];
            if (config3[BIT_FULL_SPEED] && asserted && fan_duty[f*8 +: 8] != DUTY_OFF) begin
                next_fan[f*8 +: 8] = DUTY_FULL;
            end
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == ADDR_R1_CFG) begin
            next_rdata = ch_cfg[0];
        end else if (reg_addr == ADDR_LOC_CFG) begin
            next_rdata = ch_cfg[1];
        end else if (reg_addr == ADDR_R2_CFG) begin
            next_rdata = ch_cfg[2];
        end else if (reg_addr == ADDR_R1_CRIT) begin
            next_rdata = crit[0];
        end else if (reg_addr == ADDR_LOC_CRIT) begin
            next_rdata = crit[1];
        end else if (reg_addr == ADDR_R2_CRIT) begin
            next_rdata = crit[2];
        end else if (reg_addr == ADDR_STATUS2) begin
            next_rdata = {2'h0, flag, 5'h00};
        end else if (reg_addr == ADDR_MASK2) begin
            next_rdata = mask2;
        end else if (reg_addr == ADDR_CONFIG3) begin
            next_rdata = config3;
        end else if (reg_addr == ADDR_TIMER) begin
            next_rdata = timer;
        end else if (reg_addr == ADDR_TLIMIT) begin
            next_rdata = tlimit;
        end else if (reg_addr == ADDR_CONFIG4) begin
            next_rdata = config4;
        end
    end

    // State registers, frozen while clk_en is low
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 3; i++) begin
                ch_cfg[i] <= RESET_CFG;
                crit[i] <= RESET_LIMIT;
            end
            mask2 <= RESET_CFG;
            config3 <= RESET_CFG;
            tlimit <= RESET_TLIMIT;
            config4 <= RESET_CFG;
            timer <= 8'h00;
            tick_cnt <= 32'h0;
            flag <= 1'b0;
            over <= 3'h0;
            held <= 3'h0;
            reg_rdata <= 8'h00;
            throttle_out <= 1'b0;
            throttle_oe <= 1'b1;
            smb_alert_n <= 1'b1;
            fan_duty_out <= '0;
            thermal_throttle_line_pin_select <= 1'b0;
        end else if (clk_en) begin
            ch_cfg <= next_ch_cfg;
            crit <= next_crit;
            mask2 <= next_mask2;
            config3 <= next_config3;
            tlimit <= next_tlimit;
            config4 <= next_config4;
            timer <= next_timer;
            tick_cnt <= next_tick_cnt;
            flag <= next_flag;
            over <= next_over;
            held <= next_held;
            reg_rdata <= next_rdata;
            throttle_out <= next_thr_out;
            throttle_oe <= next_oe;
            smb_alert_n <= next_alert_n;
            fan_duty_out <= next_fan;
            thermal_throttle_line_pin_select <= mon_on;
        end
    end

    // Flag reaches the alert within one cycle unless masked
    a_alert_follows: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && hit && !next_mask2[BIT_MASK_TLIMIT] |=> !smb_alert_n)
        else $error("alert missing after limit hit");
    a_mask_blocks: assert property (@(posedge ref_clk) disable iff (!arst_n)
        mask2[BIT_MASK_TLIMIT] && $stable(mask2) |-> smb_alert_n)
        else $error("alert raised while masked");
    a_off_no_count: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && !mon_on && !timer_rd |=> $stable(timer))
        else $error("timer moved while disabled");
    a_first_bit: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && asserted && timer == 8'h00 |=> timer == 8'h01)
        else $error("bit 0 not set on first assertion");
    a_first_step: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && timer == 8'h01 && !timer_rd && tick_cnt < 32'(FIRST_TICKS - 1)
        |=> timer == 8'h01)
        else $error("first count ended before two ticks");
    a_saturate: assert property (@(posedge ref_clk) disable iff (!arst_n)
        timer == 8'hff && !timer_rd |=> timer == 8'hff)
        else $error("timer left full scale");
    a_read_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && timer_rd |=> timer == {7'h00, $past(asserted)})
        else $error("timer not cleared on read");
    a_zero_limit: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && asserted && tlimit == 8'h00 |=> flag)
        else $error("zero limit did not flag");
    a_full_speed_on_throttle_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && !config3[BIT_FULL_SPEED] |=> fan_duty_out == $past(fan_duty))
        else $error("fans changed without full_speed_on_throttle");
    a_drive_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !throttle_oe |-> !throttle_out)
        else $error("throttle driven high");
endmodule // tttal_top

//--- dv/tttal_hot_model.sv
// Far-side model: processor hot source sharing the pulled-up throttle line
`timescale 1ns/10ps
module tttal_hot_model (
    input wire logic hot,
    input wire logic throttle_oe,
    output logic throttle_in
);
    // Pull-up wins only when neither party pulls low
    assign throttle_in = !(hot || !throttle_oe);
endmodule // tttal_hot_model

//--- dv/tb_top.sv
// Self-checking bench for the throttle timer, full_speed_on_throttle and output drive
`timescale 1ns/10ps
module tb_top;
    import tttal_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic hot = 1'b0;
    logic throttle_in, throttle_out, throttle_oe, smb_alert_n, thermal_throttle_line_pin_select;
    logic twos_mode = 1'b1;
    logic meas_valid = 1'b0;
    logic [1:0] meas_chan = 2'h0;
    logic [7:0] meas_temp = 8'h00;
    logic meas_quarter = 1'b0;
    logic cycle_done = 1'b0;
    logic [23:0] fan_duty = 24'h0;
    logic [23:0] fan_duty_out;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    always #25 ref_clk = ~ref_clk;
    tttal_hot_model u_hot (.hot(hot), .throttle_oe(throttle_oe), .throttle_in(throttle_in));
    tttal_top #(.TICK_CYC(4), .NFAN(3)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .clk_en(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .throttle_in(throttle_in),
        .throttle_out(throttle_out), .throttle_oe(throttle_oe), .twos_mode(twos_mode),
        .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_temp(meas_temp),
        .meas_quarter(meas_quarter), .cycle_done(cycle_done), .fan_duty(fan_duty),
        .fan_duty_out(fan_duty_out), .smb_alert_n(smb_alert_n),
        .thermal_throttle_line_pin_select(thermal_throttle_line_pin_select));
    task automatic final_report();
        if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard, far above the longest scenario
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        idle(1);
        reg_wr = 1'b0;
        idle(1);
    endtask
    // Data is registered, so it is taken one cycle after the strobe
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        idle(1);
        reg_rd = 1'b0;
        d = reg_rdata;
        idle(1);
    endtask
    task automatic meas(logic [7:0] t, logic q);
        meas_chan = 2'h1;
        meas_temp = t;
        meas_quarter = q;
        meas_valid = 1'b1;
        idle(1);
        meas_valid = 1'b0;
        idle(2);
    endtask
    // Release the line, then clear timer and status
    task automatic end_hot();
        logic [7:0] d;
        hot = 1'b0;
        idle(2);
        rd(ADDR_TIMER, d);
        rd(ADDR_STATUS2, d);
    endtask
    task automatic t_disabled();
        logic [7:0] d;
        rd(ADDR_CONFIG3, d);
        chk("config3 reset", 24'h0, d);
        wr(ADDR_CONFIG4, 8'h01);
        hot = 1'b1;
        idle(20);
        hot = 1'b0;
        idle(2);
        chk("alert off", 24'h1, smb_alert_n);
        chk("select off", 24'h0, thermal_throttle_line_pin_select);
        rd(ADDR_TIMER, d);
        chk("timer off", 24'h0, d);
    endtask
    task automatic t_first();
        logic [7:0] d;
        wr(ADDR_CONFIG3, 8'h02);
        idle(2);
        chk("pin select", 24'h1, thermal_throttle_line_pin_select);
        wr(ADDR_CONFIG4, 8'h02);
        chk("pin alert", 24'h0, thermal_throttle_line_pin_select);
        wr(ADDR_CONFIG4, 8'h03);
        chk("pin gpio", 24'h0, thermal_throttle_line_pin_select);
        wr(ADDR_CONFIG4, 8'h01);
        hot = 1'b1;
        idle(4);
        chk("alert first", 24'h0, smb_alert_n);
        rd(ADDR_STATUS2, d);
        chk("flag", 24'h1, d[BIT_TLIMIT_FLAG]);
        end_hot();
        idle(2);
        chk("alert cleared", 24'h1, smb_alert_n);
        wr(ADDR_MASK2, 8'h20);
        hot = 1'b1;
        idle(4);
        chk("alert masked", 24'h1, smb_alert_n);
        rd(ADDR_STATUS2, d);
        chk("flag masked", 24'h1, d[BIT_TLIMIT_FLAG]);
        end_hot();
        wr(ADDR_MASK2, 8'h00);
    endtask
    task automatic t_limit();
        logic [7:0] d;
        wr(ADDR_TLIMIT, 8'h01);
        hot = 1'b1;
        idle(8);
        chk("alert early", 24'h1, smb_alert_n);
        idle(4);
        chk("alert late", 24'h0, smb_alert_n);
        end_hot();
        hot = 1'b1;
        idle(1100);
        hot = 1'b0;
        idle(2);
        rd(ADDR_TIMER, d);
        chk("timer full", 24'hff, d);
        rd(ADDR_TIMER, d);
        chk("timer read clr", 24'h0, d);
        rd(ADDR_STATUS2, d);
    endtask
    task automatic t_full_speed_on_throttle();
        fan_duty = 24'h00_40_80;
        wr(ADDR_CONFIG3, 8'h06);
        hot = 1'b1;
        idle(3);
        chk("full_speed_on_throttle", 24'h00_ff_ff, fan_duty_out);
        wr(ADDR_CONFIG3, 8'h02);
        idle(2);
        chk("no full_speed_on_throttle", 24'h00_40_80, fan_duty_out);
        end_hot();
    endtask
    task automatic t_output();
        wr(ADDR_LOC_CFG, 8'h08);
        wr(ADDR_LOC_CRIT, 8'h50);
        meas(8'h50, 1'b0);
        chk("equal no drive", 24'h1, throttle_oe);
        meas(8'h50, 1'b1);
        chk("over drives", 24'h0, throttle_oe);
        meas(8'h20, 1'b0);
        chk("min hold", 24'h0, throttle_oe);
        cycle_done = 1'b1;
        idle(1);
        cycle_done = 1'b0;
        meas(8'h60, 1'b0);
        chk("stay low", 24'h0, throttle_oe);
        meas(8'h50, 1'b0);
        chk("release", 24'h1, throttle_oe);
        wr(ADDR_LOC_CRIT, TWOS_MIN_LIMIT);
        meas(8'h10, 1'b0);
        chk("twos disabled", 24'h1, throttle_oe);
        twos_mode = 1'b0;
        wr(ADDR_LOC_CRIT, OFFSET_MIN_LIMIT);
        meas(8'h40, 1'b0);
        chk("offset disabled", 24'h1, throttle_oe);
        chk("line out", 24'h0, throttle_out);
    endtask
    initial begin
        idle(3);
        arst_n = 1'b1;
        idle(1);
        t_disabled();
        t_first();
        t_limit();
        t_full_speed_on_throttle();
        t_output();
        final_report();
    end
endmodule // tb_top
